// ===== hw/dcs_map.svh
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
`define DCS_OFF_CTRL_ONE 8'h00
`define DCS_OFF_TUNING 8'h04
`define DCS_OFF_CTRL_TWO 8'h08
`define DCS_OFF_INT_FLAG 8'h0c
`define DCS_OFF_STATUS 8'h10
`define DCS_RANGE_LSB 0
`define DCS_MOD_LSB 0
`define DCS_TAP_LSB 5
`define DCS_SUB_SEL_BIT 3
`define DCS_MAIN_SEL_LSB 6
`define DCS_FAULT_BIT 1
`define DCS_RANGE_RST 4'h7
`define DCS_RANGE_MAX 4'hf
`define DCS_RANGE_HI 4'hd
`define DCS_RANGE_LO 4'hc
`define DCS_MAIN_SEL_RST 2'h0
`define DCS_DEAD_US 20
`define DCS_CLK_MHZ 125
`define DCS_DEAD_CYC (`DCS_DEAD_US * `DCS_CLK_MHZ)
`endif

// ===== hw/dcs_pkg.sv
package dcs_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dcs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dcs_apb_rsp_t;

  typedef enum logic [1:0] {
    DCS_SRC_OSC_A = 2'h0,
    DCS_SRC_OSC_B = 2'h1,
    DCS_SRC_XTAL = 2'h2,
    DCS_SRC_LPO = 2'h3
  } dcs_main_src_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic [4:0] acc;
    logic tick;
  } dcs_core_st_t;

  typedef struct packed {
    logic [3:0] range;
    logic [2:0] tap;
    logic [4:0] modul;
    dcs_main_src_t main_sel;
    logic sub_sel;
    logic fault;
    logic osc_en;
    logic [11:0] dead_cnt;
    logic hung;
    dcs_apb_rsp_t rsp;
    logic main_clk;
    logic sub_clk;
  } dcs_st_t;
endpackage

// ===== hw/dcs_osc_core.sv
`timescale 1ns/100ps
`include "dcs_map.svh"
// digital stand-in for the oscillator: emits one-cycle ticks
module dcs_osc_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic halt,
  input wire logic [3:0] range,
  input wire logic [2:0] tap,
  input wire logic [4:0] modul,
  output logic tick
);
  dcs_pkg::dcs_core_st_t s_r;
  dcs_pkg::dcs_core_st_t s_nxt;
  logic [6:0] load;
  logic [5:0] sum;

  // higher range and tap give a shorter period
  assign load = {~range, ~tap};
  assign sum = {1'b0, s_r.acc} + {1'b0, modul};

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!enable || halt) begin
      s_nxt.cnt = load;
    end else if (s_r.cnt == 7'h00) begin
      s_nxt.tick = 1'b1;
      s_nxt.acc = sum[4:0];
      // modulation stretches some periods by one cycle
      s_nxt.cnt = load + {6'h00, sum[5]};
    end else begin
      s_nxt.cnt = s_r.cnt - 7'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// ===== hw/dcs_clock_ctrl.sv
`timescale 1ns/100ps
`include "dcs_map.svh"
module dcs_clock_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input dcs_pkg::dcs_apb_req_t apb_req,
  output dcs_pkg::dcs_apb_rsp_t apb_rsp,
  input wire logic xtal_tick,
  input wire logic lpo_tick,
  input wire logic osc_fault_in,
  output logic main_clock,
  output logic sub_main_clock,
  output logic osc_running
);
  dcs_pkg::dcs_st_t s_r;
  dcs_pkg::dcs_st_t s_nxt;
  logic osc_tick;
  logic access;
  logic wr;
  logic main_osc;
  logic sub_osc;
  logic halt;
  logic [7:0] wd;
  logic [3:0] wd_range;
  logic wr_one;
  logic wr_tune;
  logic wr_two;
  logic wr_flag;
  logic tune_diff;

  localparam logic [11:0] DEAD_CYC = 12'(`DCS_DEAD_CYC);

  function automatic logic is_osc_src(input logic [1:0] sel);
    is_osc_src = (sel == dcs_pkg::DCS_SRC_OSC_A) || (sel == dcs_pkg::DCS_SRC_OSC_B);
  endfunction

  function automatic logic crosses_gap(input logic [3:0] a, input logic [3:0] b);
    // full 4-bit span, values 0..15
    crosses_gap = (a > `DCS_RANGE_HI && b < `DCS_RANGE_LO) ||
                  (a < `DCS_RANGE_LO && b > `DCS_RANGE_HI);
  endfunction

  function automatic logic tune_changes(input logic [7:0] d, input logic [2:0] t,
                                        input logic [4:0] m);
    tune_changes = (d != {t, m});
  endfunction

  assign access = apb_req.psel && apb_req.penable;
  assign wr = access && s_r.rsp.pready && apb_req.pwrite;
  assign wd = apb_req.pwdata[7:0];
  assign wd_range = wd[3:0];
  assign wr_one = wr && (apb_req.paddr == `DCS_OFF_CTRL_ONE);
  assign wr_tune = wr && (apb_req.paddr == `DCS_OFF_TUNING);
  assign wr_two = wr && (apb_req.paddr == `DCS_OFF_CTRL_TWO);
  assign wr_flag = wr && (apb_req.paddr == `DCS_OFF_INT_FLAG);
  assign tune_diff = tune_changes(wd, s_r.tap, s_r.modul);
  // a pending fault overrides the main select toward the oscillator
  assign main_osc = is_osc_src(s_r.main_sel) || s_r.fault;
  assign sub_osc = !s_r.sub_sel;
  assign halt = (s_r.dead_cnt != 12'h000) || s_r.hung;

  dcs_osc_core u_core (
    .clock(clock),
    .rst_n(rst_n),
    .enable(s_r.osc_en),
    .halt(halt),
    .range(s_r.range),
    .tap(s_r.tap),
    .modul(s_r.modul),
    .tick(osc_tick)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp.pready = access && !s_r.rsp.pready;
    s_nxt.rsp.pslverr = 1'b0;
    if (access && !s_r.rsp.pready) begin
      s_nxt.rsp.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        `DCS_OFF_CTRL_ONE: s_nxt.rsp.prdata[3:0] = s_r.range;
        `DCS_OFF_TUNING: s_nxt.rsp.prdata[7:0] = {s_r.tap, s_r.modul};
        `DCS_OFF_CTRL_TWO: begin
          s_nxt.rsp.prdata[7:6] = s_r.main_sel;
          s_nxt.rsp.prdata[`DCS_SUB_SEL_BIT] = s_r.sub_sel;
        end
        `DCS_OFF_INT_FLAG: s_nxt.rsp.prdata[`DCS_FAULT_BIT] = s_r.fault;
        `DCS_OFF_STATUS: s_nxt.rsp.prdata[3:0] = {s_r.osc_en, halt, s_r.hung, osc_tick};
        default: s_nxt.rsp.pslverr = 1'b1;
      endcase
    end
    if (s_r.dead_cnt != 12'h000) begin
      s_nxt.dead_cnt = s_r.dead_cnt - 12'h001;
    end
    if (wr) begin
      case (apb_req.paddr)
        `DCS_OFF_CTRL_ONE: begin
          s_nxt.range = wd[3:0];
          // a second upset during dead time is where the hang shows up
          if (s_r.osc_en && crosses_gap(s_r.range, wd[3:0])) begin
            if (halt) begin
              s_nxt.hung = 1'b1;
            end else begin
              s_nxt.dead_cnt = DEAD_CYC;
            end
          end
        end
        `DCS_OFF_TUNING: begin
          s_nxt.tap = wd[7:5];
          s_nxt.modul = wd[4:0];
          if (s_r.osc_en && s_r.range == `DCS_RANGE_MAX &&
              wd != {s_r.tap, s_r.modul}) begin
            if (halt) begin
              s_nxt.hung = 1'b1;
            end else begin
              s_nxt.dead_cnt = DEAD_CYC;
            end
          end
        end
        `DCS_OFF_CTRL_TWO: begin
          s_nxt.main_sel = dcs_pkg::dcs_main_src_t'(wd[7:6]);
          s_nxt.sub_sel = wd[`DCS_SUB_SEL_BIT];
        end
        `DCS_OFF_INT_FLAG: s_nxt.fault = wd[`DCS_FAULT_BIT];
        default: s_nxt.sub_sel = s_r.sub_sel;
      endcase
    end
    // hardware set beats a software clear in the same cycle
    if (osc_fault_in) begin
      s_nxt.fault = 1'b1;
    end
    // sub clock may only keep an oscillator already running
    s_nxt.osc_en = main_osc || (sub_osc && s_r.osc_en);
    case (s_r.main_sel)
      dcs_pkg::DCS_SRC_XTAL: s_nxt.main_clk = s_r.main_clk ^ (main_osc ? osc_tick : xtal_tick);
      dcs_pkg::DCS_SRC_LPO: s_nxt.main_clk = s_r.main_clk ^ (main_osc ? osc_tick : lpo_tick);
      default: s_nxt.main_clk = s_r.main_clk ^ osc_tick;
    endcase
    if (!sub_osc) begin
      s_nxt.sub_clk = s_r.sub_clk ^ xtal_tick;
    end else if (!s_r.osc_en) begin
      s_nxt.sub_clk = 1'b1;
    end else begin
      s_nxt.sub_clk = s_r.sub_clk ^ osc_tick;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.range <= `DCS_RANGE_RST;
      s_r.main_sel <= dcs_pkg::dcs_main_src_t'(`DCS_MAIN_SEL_RST);
      s_r.osc_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign apb_rsp = s_r.rsp;
  assign main_clock = s_r.main_clk;
  assign sub_main_clock = s_r.sub_clk;
  assign osc_running = s_r.osc_en;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  reset_range_a: assert property ($rose(rst_n) |-> s_r.range == `DCS_RANGE_RST)
    else $error("range not at default after reset");

  reset_state_a: assert property (
      $rose(rst_n)
      |-> s_r.osc_en && !s_r.hung && s_r.dead_cnt == 12'h000)
    else $error("state not clean after reset");

  cross_dead_a: assert property (
      wr && apb_req.paddr == `DCS_OFF_CTRL_ONE && s_r.osc_en &&
      crosses_gap(s_r.range, wd[3:0]) |=> halt)
    else $error("gap crossing did not halt oscillator");

  dead_load_a: assert property (
      wr_one && s_r.osc_en && crosses_gap(s_r.range, wd_range) && !halt
      |=> s_r.dead_cnt == DEAD_CYC)
    else $error("gap crossing did not load dead time");

  hang_set_a: assert property (
      wr_one && s_r.osc_en && crosses_gap(s_r.range, wd_range) && halt
      |=> s_r.hung)
    else $error("second upset did not hang oscillator");

  hang_keep_a: assert property (
      s_r.hung
      |=> s_r.hung && halt)
    else $error("hung oscillator recovered without reset");

  dead_count_a: assert property (
      s_r.dead_cnt != 12'h000
      |=> s_r.dead_cnt == $past(s_r.dead_cnt) - 12'h001)
    else $error("dead time counter skipped");

  dead_end_a: assert property (
      s_r.dead_cnt == 12'h001 && !s_r.hung && !wr
      |=> !halt)
    else $error("dead time did not end");

  dead_hold_a: assert property ($rose(s_r.dead_cnt == DEAD_CYC) |-> halt [*8] ##1 !osc_tick)
    else $error("dead time ended too early");

  halt_quiet_a: assert property (
      halt
      |=> !osc_tick)
    else $error("oscillator ticked while halted");

  tune_hazard_a: assert property (
      wr && apb_req.paddr == `DCS_OFF_TUNING && s_r.osc_en &&
      s_r.range == `DCS_RANGE_MAX && wd != {s_r.tap, s_r.modul} |=> halt)
    else $error("tuning at full range did not halt");

  tune_hang_a: assert property (
      wr_tune && s_r.osc_en && s_r.range == `DCS_RANGE_MAX && tune_diff && halt
      |=> s_r.hung)
    else $error("tuning while halted did not hang");

  tune_safe_a: assert property (
      wr_tune && s_r.range != `DCS_RANGE_MAX && !halt
      |=> !halt)
    else $error("tuning below full range halted");

  step_safe_a: assert property (
      wr_one && !crosses_gap(s_r.range, wd_range) && !halt
      |=> !halt)
    else $error("safe range step halted oscillator");

  range_write_a: assert property (
      wr_one
      |=> s_r.range == $past(wd_range))
    else $error("range write lost");

  range_read_a: assert property (
      access && !s_r.rsp.pready && apb_req.paddr == `DCS_OFF_CTRL_ONE
      |=> apb_rsp.prdata == {28'h0000000, s_r.range})
    else $error("range read wrong");

  osc_off_a: assert property (!main_osc && !sub_osc |=> !s_r.osc_en)
    else $error("oscillator on while unselected");

  sub_keep_a: assert property (
      sub_osc && s_r.osc_en
      |=> s_r.osc_en)
    else $error("sub clock dropped running oscillator");

  sub_only_a: assert property (!s_r.osc_en && !main_osc |=> !s_r.osc_en)
    else $error("sub clock started oscillator");

  sub_high_a: assert property (sub_osc && !s_r.osc_en |=> sub_main_clock)
    else $error("sub clock not held high");

  sub_sel_a: assert property (
      wr_two && wd[`DCS_SUB_SEL_BIT]
      |=> s_r.sub_sel)
    else $error("sub source write lost");

  main_start_a: assert property (!s_r.main_sel[1] |=> s_r.osc_en)
    else $error("main select did not start oscillator");

  main_follow_a: assert property (
      main_osc
      |=> main_clock == ($past(main_clock) ^ $past(osc_tick)))
    else $error("main clock not driven by oscillator");

  fault_set_a: assert property (osc_fault_in |=> s_r.fault ##1 s_r.osc_en)
    else $error("fault did not force oscillator");

  fault_run_a: assert property (
      s_r.fault
      |=> s_r.osc_en)
    else $error("pending fault left oscillator off");

  fault_hold_a: assert property (
      s_r.fault && !wr_flag
      |=> s_r.fault)
    else $error("fault flag dropped by itself");

  fault_clear_a: assert property (
      wr_flag && !wd[`DCS_FAULT_BIT] && !osc_fault_in
      |=> !s_r.fault)
    else $error("fault flag clear lost");

  xtal_follow_a: assert property (
      !main_osc && s_r.main_sel == dcs_pkg::DCS_SRC_XTAL
      |=> main_clock == ($past(main_clock) ^ $past(xtal_tick)))
    else $error("main clock not driven by crystal");
endmodule

// ===== verif/tb_dcs_clock_ctrl.sv
`timescale 1ns/100ps
module tb_dcs_clock_ctrl;
  typedef struct {
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] m;
    logic err;
    logic sub;
    int wt;
  } dcs_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic xtal_tick = 1'b0;
  logic lpo_tick = 1'b0;
  logic osc_fault_in = 1'b0;
  logic main_clock;
  logic sub_main_clock;
  logic osc_running;
  logic [31:0] q;
  logic e;
  logic mc;
  int cyc = 0;
  int errors = 0;
  int n_tests = 0;
  dcs_pkg::dcs_apb_req_t apb_req = '0;
  dcs_pkg::dcs_apb_rsp_t apb_rsp;
  // status reads mask bit 0, the live oscillator tick
  dcs_row_t rows [30] = '{
    '{0, 8'h00, 8'h07, 8'h0f, 0, 0, 0}, '{0, 8'h04, 8'h00, 8'hff, 0, 0, 0},
    '{0, 8'h08, 8'h00, 8'hff, 0, 0, 0}, '{0, 8'h10, 8'h08, 8'h0e, 0, 0, 0},
    '{1, 8'h00, 8'h0d, 8'h00, 0, 0, 0}, '{1, 8'h00, 8'h05, 8'h00, 0, 0, 0},
    '{0, 8'h10, 8'h08, 8'h0e, 0, 0, 0}, '{1, 8'h08, 8'h80, 8'h00, 0, 0, 0},
    '{0, 8'h10, 8'h08, 8'h0e, 0, 0, 0}, '{1, 8'h08, 8'h88, 8'h00, 0, 0, 0},
    '{0, 8'h10, 8'h00, 8'h0e, 0, 0, 0}, '{1, 8'h08, 8'h80, 8'h00, 0, 0, 0},
    '{0, 8'h10, 8'h00, 8'h0e, 0, 1, 0}, '{1, 8'h08, 8'h40, 8'h00, 0, 0, 0},
    '{0, 8'h10, 8'h08, 8'h0e, 0, 0, 0}, '{1, 8'h08, 8'h88, 8'h00, 0, 0, 0},
    '{1, 8'h08, 8'h08, 8'h00, 0, 0, 0}, '{0, 8'h10, 8'h08, 8'h0e, 0, 0, 0},
    '{1, 8'h08, 8'h88, 8'h00, 0, 0, 0}, '{1, 8'h0c, 8'h02, 8'h00, 0, 0, 0},
    '{0, 8'h10, 8'h08, 8'h0e, 0, 0, 0}, '{1, 8'h0c, 8'h00, 8'h00, 0, 0, 0},
    '{0, 8'h10, 8'h00, 8'h0e, 0, 0, 0}, '{1, 8'h08, 8'h00, 8'h00, 0, 0, 0},
    '{0, 8'h14, 8'h00, 8'hff, 1, 0, 0}, '{1, 8'h00, 8'h0f, 8'h00, 0, 0, 0},
    '{0, 8'h10, 8'h0c, 8'h0e, 0, 0, 2600}, '{0, 8'h10, 8'h08, 8'h0e, 0, 0, 0},
    '{1, 8'h04, 8'h21, 8'h00, 0, 0, 0}, '{0, 8'h10, 8'h0c, 8'h0e, 0, 0, 0}
  };
  dcs_clock_ctrl DUT (
    .clock(clock),
    .rst_n(rst_n),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .xtal_tick(xtal_tick),
    .lpo_tick(lpo_tick),
    .osc_fault_in(osc_fault_in),
    .main_clock(main_clock),
    .sub_main_clock(sub_main_clock),
    .osc_running(osc_running)
  );
  initial begin
    forever #4 clock = ~clock;
  end
  task finish_test;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    xtal_tick <= (cyc[1:0] == 2'h0);
    lpo_tick <= (cyc[3:0] == 4'h0);
    if (cyc == 12000) begin
      errors = errors + 1;
      finish_test();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, {24'h0, rows[i].d});
      check(e, rows[i].err);
      if (!rows[i].wr) check(q & {24'hffffff, rows[i].m}, {24'h0, rows[i].d & rows[i].m});
      if (rows[i].sub) check(sub_main_clock, 1'b1);
      repeat (rows[i].wt) @(posedge clock);
    end
    // a tuning change while already halted leaves the oscillator hung
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(q & 32'he, 32'he);
    mc = main_clock;
    repeat (40) @(posedge clock);
    check(main_clock, mc);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(q, 32'h7);
    apb(1'b0, 8'h10, 32'h0);
    check(q & 32'he, 32'h8);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h9);
    apb(1'b1, 8'h04, 32'h35);
    for (int r = 10; r < 16; r++) apb(1'b1, 8'h00, r);
    apb(1'b1, 8'h00, 32'hd);
    apb(1'b1, 8'h00, 32'h7);
    apb(1'b1, 8'h04, 32'h4a);
    apb(1'b0, 8'h10, 32'h0);
    check(q & 32'he, 32'h8);
    apb(1'b1, 8'h00, 32'h7);
    apb(1'b1, 8'h00, 32'he);
    apb(1'b0, 8'h10, 32'h0);
    check(q & 32'he, 32'hc);
    osc_fault_in <= 1'b1;
    @(posedge clock);
    osc_fault_in <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0);
    check(q, 32'h2);
    apb(1'b1, 8'h08, 32'h88);
    repeat (2) @(posedge clock);
    check(osc_running, 1'b1);
    apb(1'b1, 8'h0c, 32'h0);
    repeat (2) @(posedge clock);
    check(osc_running, 1'b0);
    mc = main_clock;
    repeat (4) @(posedge clock);
    check(main_clock, !mc);
    finish_test();
  end
endmodule
